// [inc/sia_pkg.sv]
// constants and types for the sensor register access port over two-wire link
// assumes one 200 MHz system clock; pins arrive unsynchronised
package sia_pkg;
  // ****************************************************************
  // link and map
  // ****************************************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h1a;
  localparam logic [15:0] REG_BASE = 16'h3000;
  localparam logic [15:0] REG_LAST = 16'h34ff;
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned NUM_PAGES = 5;
  localparam int unsigned REG_BYTES = PAGE_BYTES * NUM_PAGES;
  localparam int unsigned IDX_W = 11;
  localparam logic [15:0] STANDBY_ADDR = 16'h3000;
  localparam logic [15:0] HOLD_ADDR = 16'h3001;
  localparam logic STANDBY_RST = 1'b1;
  localparam logic HOLD_RST = 1'b0;
  localparam int unsigned STANDBY_BIT = 0;
  localparam int unsigned HOLD_BIT = 0;
  // immediate-class address ranges; all other bytes are frame class
  localparam logic [15:0] IMM_A_LO = 16'h3000;
  localparam logic [15:0] IMM_A_HI = 16'h3003;
  localparam logic [15:0] IMM_B_LO = 16'h3046;
  localparam logic [15:0] IMM_B_HI = 16'h304b;
  localparam logic [15:0] IMM_C_LO = 16'h305c;
  localparam logic [15:0] IMM_C_HI = 16'h305f;
  localparam logic [15:0] IMM_D = 16'h309e;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic en;
    logic imm;
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
  } sia_wr_t;

  typedef enum {ST_IDLE, ST_RX_BYTE, ST_RX_ACK, ST_TX_BYTE, ST_TX_ACK}
    sia_state_t;
endpackage

// [design/sia_i2c_regs.sv]
// two-wire slave with 1280-byte register space and frame reflection
// assumes scl, sda and sync arrive asynchronous; scl far below clk/8
`timescale 1ns/1ps
module sia_i2c_regs #(
  parameter int unsigned REG_BYTES = sia_pkg::REG_BYTES
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic VERT_SYNC_IN,
  input wire logic [sia_pkg::IDX_W-1:0] ACT_ADDR_IN,
  output logic [7:0] ACT_DATA_OUT,
  output logic STANDBY_OUT,
  output logic FRAME_HOLD_OUT,
  output logic REFLECT_BUSY_OUT
);
  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (REG_BYTES == 0 || REG_BYTES > (1 << sia_pkg::IDX_W))
  begin : g_bad_size
    $error("REG_BYTES must be 1..2048");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;
  logic vs_s1_r, vs_s2_r, vs_d_r;

  // two flops per pin, third stage only for edge detection
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
      vs_s1_r <= 1'b1;
      vs_s2_r <= 1'b1;
      vs_d_r <= 1'b1;
    end
    else
    begin
      scl_s1_r <= SCL_IN;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= SDA_IN;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
      vs_s1_r <= VERT_SYNC_IN;
      vs_s2_r <= vs_s1_r;
      vs_d_r <= vs_s2_r;
    end
  end

  // edge and condition detect on the synchronised copies
  logic scl_rise, scl_fall, start_det, stop_det, vs_fall;
  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;
  assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  assign vs_fall = ~vs_s2_r & vs_d_r;

  // ****************************************************************
  // protocol engine
  // ****************************************************************
  sia_pkg::sia_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r, tx_r, rd_data_r;
  logic first_r, rd_mode_r, mst_ack_r, sda_oe_r;
  logic [1:0] byte_cnt_r;
  logic [15:0] idx_r;
  logic [7:0] byte_in;
  logic byte_done, addr_match, in_range;
  logic [sia_pkg::IDX_W-1:0] idx_off;
  sia_pkg::sia_wr_t wr;

  assign byte_in = {shift_r[6:0], sda_s2_r};
  assign byte_done = (state_r == sia_pkg::ST_RX_BYTE) && scl_rise &&
    (bit_cnt_r == 3'h7);
  assign addr_match = (byte_in[7:1] == sia_pkg::SLAVE_ADDR);
  assign in_range = (idx_r >= sia_pkg::REG_BASE) &&
    (idx_r <= sia_pkg::REG_LAST);
  assign idx_off = sia_pkg::IDX_W'(idx_r - sia_pkg::REG_BASE);

  // write strobe: fourth and later bytes of a write phase, past both index bytes
  always_comb
  begin
    wr.en = byte_done && !first_r && (byte_cnt_r == 2'h2) && in_range;
    wr.imm = ((idx_r >= sia_pkg::IMM_A_LO) && (idx_r <= sia_pkg::IMM_A_HI))
      || ((idx_r >= sia_pkg::IMM_B_LO) && (idx_r <= sia_pkg::IMM_B_HI))
      || ((idx_r >= sia_pkg::IMM_C_LO) && (idx_r <= sia_pkg::IMM_C_HI))
      || (idx_r == sia_pkg::IMM_D);
    wr.idx = idx_off;
    wr.data = byte_in;
  end

  // bit engine: sample on scl rise, drive on scl fall
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_r <= sia_pkg::ST_IDLE;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      first_r <= 1'b0;
      rd_mode_r <= 1'b0;
      mst_ack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      byte_cnt_r <= 2'h0;
      idx_r <= 16'h0000;
    end
    else if (stop_det)
    begin
      state_r <= sia_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (start_det)
    begin
      // index untouched: a start without stop continues the transaction
      state_r <= sia_pkg::ST_RX_BYTE;
      bit_cnt_r <= 3'h0;
      first_r <= 1'b1;
      byte_cnt_r <= 2'h0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        sia_pkg::ST_RX_BYTE:
        begin
          if (scl_rise)
          begin
            shift_r <= byte_in;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7)
            begin
              if (first_r && !addr_match)
                state_r <= sia_pkg::ST_IDLE;
              else
                state_r <= sia_pkg::ST_RX_ACK;
              if (first_r)
                rd_mode_r <= byte_in[0];
            end
          end
        end
        sia_pkg::ST_RX_ACK:
        begin
          if (scl_fall && !sda_oe_r)
          begin
            sda_oe_r <= 1'b1;
            if (!first_r)
            begin
              case (byte_cnt_r)
                2'h0: idx_r[15:8] <= shift_r;
                2'h1: idx_r[7:0] <= shift_r;
                default: idx_r <= idx_r + 16'h1;
              endcase
              if (byte_cnt_r != 2'h2)
                byte_cnt_r <= byte_cnt_r + 2'h1;
            end
          end
          else if (scl_fall)
          begin
            first_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            if (first_r && rd_mode_r)
            begin
              // msb of the indexed byte goes out straight after the ack
              state_r <= sia_pkg::ST_TX_BYTE;
              sda_oe_r <= ~rd_data_r[7];
              tx_r <= {rd_data_r[6:0], 1'b0};
            end
            else
            begin
              state_r <= sia_pkg::ST_RX_BYTE;
              sda_oe_r <= 1'b0;
            end
          end
        end
        sia_pkg::ST_TX_BYTE:
        begin
          if (scl_fall)
          begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7)
            begin
              sda_oe_r <= 1'b0;
              state_r <= sia_pkg::ST_TX_ACK;
            end
            else
            begin
              sda_oe_r <= ~tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          end
        end
        sia_pkg::ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            idx_r <= idx_r + 16'h1;
            mst_ack_r <= ~sda_s2_r;
          end
          else if (scl_fall)
          begin
            bit_cnt_r <= 3'h0;
            if (mst_ack_r)
            begin
              state_r <= sia_pkg::ST_TX_BYTE;
              sda_oe_r <= ~rd_data_r[7];
              tx_r <= {rd_data_r[6:0], 1'b0};
            end
            else
              state_r <= sia_pkg::ST_IDLE;
          end
        end
        sia_pkg::ST_IDLE:
        begin
          sda_oe_r <= 1'b0;
        end
        default:
        begin
          state_r <= sia_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // control registers and storage
  // ****************************************************************
  logic standby_r, hold_r;
  logic [7:0] pend_mem [REG_BYTES];
  logic [7:0] act_mem [REG_BYTES];
  logic copy_busy_r, init_r;
  logic [sia_pkg::IDX_W-1:0] copy_idx_r;
  logic [7:0] act_data_r;

  // standby and hold act at once; only bit 0 is stored
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      standby_r <= sia_pkg::STANDBY_RST;
      hold_r <= sia_pkg::HOLD_RST;
    end
    else if (wr.en && idx_r == sia_pkg::STANDBY_ADDR)
      standby_r <= byte_in[sia_pkg::STANDBY_BIT];
    else if (wr.en && idx_r == sia_pkg::HOLD_ADDR)
      hold_r <= byte_in[sia_pkg::HOLD_BIT];
  end

  // read mux registered; reserved bits and unmapped bytes read zero
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      rd_data_r <= 8'h00;
    else if (idx_r == sia_pkg::STANDBY_ADDR)
      rd_data_r <= {7'h00, standby_r};
    else if (idx_r == sia_pkg::HOLD_ADDR)
      rd_data_r <= {7'h00, hold_r};
    else if (in_range)
      rd_data_r <= pend_mem[idx_off];
    else
      rd_data_r <= 8'h00;
  end

  // written values; cleared by the init walk after reset
  always_ff @(posedge CLK_IN)
  begin
    if (init_r)
      pend_mem[copy_idx_r] <= 8'h00;
    else if (wr.en)
      pend_mem[wr.idx] <= wr.data;
  end

  // effective values seen by the sensor core
  always_ff @(posedge CLK_IN)
  begin
    if (wr.en && wr.imm && !init_r)
      act_mem[wr.idx] <= wr.data;
    else if (copy_busy_r)
      act_mem[copy_idx_r] <= init_r ? 8'h00 : pend_mem[copy_idx_r];
  end

  // frame reflection walk: one byte a cycle, fits inside sync blanking
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      copy_busy_r <= 1'b1;
      init_r <= 1'b1;
      copy_idx_r <= '0;
    end
    else if (copy_busy_r)
    begin
      if (copy_idx_r == sia_pkg::IDX_W'(REG_BYTES - 1))
      begin
        copy_busy_r <= 1'b0;
        init_r <= 1'b0;
        copy_idx_r <= '0;
      end
      else
        copy_idx_r <= copy_idx_r + 1'b1;
    end
    else if (vs_fall && !hold_r)
      copy_busy_r <= 1'b1;
  end

  // core-side readback of effective values
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      act_data_r <= 8'h00;
    else
      act_data_r <= act_mem[ACT_ADDR_IN];
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = sda_oe_r;
  assign ACT_DATA_OUT = act_data_r;
  assign STANDBY_OUT = standby_r;
  assign FRAME_HOLD_OUT = hold_r;
  assign REFLECT_BUSY_OUT = copy_busy_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_addr_seen;
    byte_done && first_r;
  endsequence
  sequence s_rd_ack_end;
    state_r == sia_pkg::ST_RX_ACK && sda_oe_r && first_r && rd_mode_r
      && scl_fall && !stop_det && !start_det;
  endsequence
  sequence s_ack_drive(logic [1:0] n);
    state_r == sia_pkg::ST_RX_ACK && scl_fall && !sda_oe_r && !first_r
      && byte_cnt_r == n && !stop_det && !start_det;
  endsequence

  AST_START_RX: assert property (start_det && !stop_det |=>
    state_r == sia_pkg::ST_RX_BYTE && bit_cnt_r == 3'h0 && first_r)
    else $error("start not followed by address reception");
  AST_RPT_KEEP_IDX: assert property (start_det |=>
    idx_r == $past(idx_r))
    else $error("index changed by start condition");
  AST_NO_ACK_FOREIGN: assert property (s_addr_seen ##0 !addr_match
    && !stop_det |=> (!sda_oe_r)[*4])
    else $error("foreign address acknowledged");
  AST_OWN_ADDR_ACK: assert property (s_addr_seen ##0 addr_match
    && !stop_det |=> state_r == sia_pkg::ST_RX_ACK && rd_mode_r == $past(
    sda_s2_r))
    else $error("own address not taken");
  AST_IDX_LOAD_LO: assert property (s_ack_drive(2'h1) |=>
    idx_r[7:0] == $past(shift_r) && sda_oe_r)
    else $error("index low byte not loaded");
  AST_WR_ADVANCE: assert property (s_ack_drive(2'h2) |=>
    idx_r == $past(idx_r) + 16'h1)
    else $error("index did not advance after write");
  AST_TX_MSB: assert property (s_rd_ack_end |=>
    state_r == sia_pkg::ST_TX_BYTE && sda_oe_r == ~$past(rd_data_r[7]))
    else $error("read byte msb not driven after ack");
  AST_TX_ADVANCE: assert property (state_r == sia_pkg::ST_TX_ACK
    && scl_rise && !stop_det && !start_det |=> idx_r == $past(idx_r)
    + 16'h1)
    else $error("index did not advance at master ack");
  AST_STANDBY_WR: assert property (wr.en
    && idx_r == sia_pkg::STANDBY_ADDR |=> standby_r == $past(byte_in[0]))
    else $error("standby bit not updated at once");
  AST_HOLD_BLOCKS: assert property (vs_fall && hold_r && !copy_busy_r
    |=> !copy_busy_r)
    else $error("reflection ran while held");
  AST_FRAME_POINT: assert property (vs_fall && !hold_r && !copy_busy_r
    |=> copy_busy_r && copy_idx_r == '0)
    else $error("reflection did not start at sync fall");
endmodule

// [tb/sia_i2c_master.sv]
// behavioural two-wire master for the sensor register port
// assumes pull-ups on scl and sda; open-drain drive, 64 ns bit period
`timescale 1ns/1ps
module sia_i2c_master (
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  // ****************************************************************
  // bus idle
  // ****************************************************************
  // scl stands still high between frames, sda released
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // ****************************************************************
  // bit level
  // ****************************************************************
  // data moves only in mid low phase, so it is steady while scl high
  task automatic put_bit(input logic b);
    sda_out = b;
    #16 scl_out = 1'b1;
    #32 scl_out = 1'b0;
    #16;
  endtask

  // sda released, sampled mid high phase
  task automatic get_bit(output logic b);
    sda_out = 1'b1;
    #16 scl_out = 1'b1;
    #16 b = sda_in;
    #16 scl_out = 1'b0;
    #16;
  endtask

  // start, or repeated start when no stop came first
  task automatic start();
    sda_out = 1'b1;
    #16 scl_out = 1'b1;
    #16 sda_out = 1'b0;
    #16 scl_out = 1'b0;
    #16;
  endtask

  // stop: sda rises while scl high, bus left idle
  task automatic stop();
    sda_out = 1'b0;
    #16 scl_out = 1'b1;
    #16 sda_out = 1'b1;
    #16;
  endtask

  // ****************************************************************
  // byte level
  // ****************************************************************
  // byte out msb first, returns the slave acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask

  // byte in msb first, then ack to go on or nack to end
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(~ack);
  endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the two-wire register port
// assumes sia_pkg and the master model are compiled before it
`timescale 1ns/1ps
module tb;
  // ****************************************************************
  // signals and cases
  // ****************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
  } sia_row_t;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic vert_sync = 1'b1;
  logic [sia_pkg::IDX_W-1:0] act_addr = '0;
  logic [7:0] act_data;
  logic sda_oe, sda_dev, scl, sda_m, standby, hold, busy, ack;
  wire sda_w;
  int mismatches = 0;
  int cmp_count = 0;
  sia_row_t rows [5] = '{'{16'h3001, 8'hfe, 8'h00},
    '{16'h3005, 8'h01, 8'h01}, '{16'h30ff, 8'ha5, 8'ha5},
    '{16'h3100, 8'h3c, 8'h3c}, '{16'h34ff, 8'hc3, 8'hc3}};

  // open-drain wire with pull-up, both parties may pull low
  assign sda_w = (sda_oe ? sda_dev : 1'b1) & sda_m;

  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;

  sia_i2c_regs uut (.CLK_IN(clk_in), .RST_N_IN(rst_n_in),
    .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_dev),
    .SDA_OE_OUT(sda_oe), .VERT_SYNC_IN(vert_sync),
    .ACT_ADDR_IN(act_addr), .ACT_DATA_OUT(act_data),
    .STANDBY_OUT(standby), .FRAME_HOLD_OUT(hold),
    .REFLECT_BUSY_OUT(busy));
  sia_i2c_master master (.scl_out(scl), .sda_out(sda_m),
    .sda_in(sda_w));

  // ****************************************************************
  // compare and link tasks
  // ****************************************************************
  task automatic cmp_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_bit(input string what, input logic e, input logic g);
    cmp_byte(what, {7'h00, e}, {7'h00, g});
  endtask

  // slave address with write bit, then the two address bytes
  task automatic addr_phase(input logic [15:0] a);
    master.start();
    master.send_byte({sia_pkg::SLAVE_ADDR, 1'b0}, ack);
    cmp_bit("ack addr w", 1'b1, ack);
    master.send_byte(a[15:8], ack);
    cmp_bit("ack addr hi", 1'b1, ack);
    master.send_byte(a[7:0], ack);
    cmp_bit("ack addr lo", 1'b1, ack);
  endtask

  // n bytes d, d+1, ... from address a; settles 8 clocks after stop
  task automatic reg_write(input logic [15:0] a, input logic [7:0] d,
                           input int n);
    addr_phase(a);
    for (int i = 0; i < n; i++)
    begin
      master.send_byte(d + 8'(i), ack);
      cmp_bit("ack data", 1'b1, ack);
    end
    master.stop();
    repeat (8) @(posedge clk_in);
  endtask

  // random (rnd) or current location read of n bytes, expects e, e+1..
  task automatic reg_read(input logic rnd, input logic [15:0] a,
                          input logic [7:0] e, input int n);
    logic [7:0] d;
    if (rnd)
      addr_phase(a);
    master.start();
    master.send_byte({sia_pkg::SLAVE_ADDR, 1'b1}, ack);
    cmp_bit("ack addr r", 1'b1, ack);
    for (int i = 0; i < n; i++)
    begin
      master.recv_byte(i < n - 1, d);
      cmp_byte("read data", e + 8'(i), d);
    end
    master.stop();
  endtask

  // bounded wait for the init walk or copy to finish
  task automatic wait_ready();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++)
      @(posedge clk_in);
    cmp_bit("busy", 1'b0, busy);
  endtask

  // sync fall; link stays quiet until the copy is over
  task automatic frame_point(input logic copy);
    @(posedge clk_in);
    #1 vert_sync = 1'b0;
    repeat (10) @(posedge clk_in);
    #1 cmp_bit("copy busy", copy, busy);
    wait_ready();
    @(posedge clk_in);
    #1 vert_sync = 1'b1;
  endtask

  // effective value seen on the core side
  task automatic eff_check(input logic [10:0] a, input logic [7:0] e);
    @(posedge clk_in);
    #1 act_addr = a;
    repeat (2) @(posedge clk_in);
    #1 cmp_byte("effective", e, act_data);
  endtask

  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  // watchdog sized well above the expected run of about 90 us
  initial
  begin
    #400000;
    mismatches++;
    complete_run();
  end

  // reset, table cases, then the awkward cases
  initial
  begin
    repeat (20) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    cmp_bit("standby rst", 1'b1, standby);
    cmp_bit("hold rst", 1'b0, hold);
    wait_ready();
    reg_read(1'b1, 16'h3000, 8'h01, 1);
    reg_read(1'b1, 16'h3001, 8'h00, 1);
    foreach (rows[i])
    begin
      reg_write(rows[i].addr, rows[i].wd, 1);
      reg_read(1'b1, rows[i].addr, rows[i].rd, 1);
    end
    // sequential run, then current location picks up the next byte
    reg_write(16'h3010, 8'h10, 4);
    reg_read(1'b1, 16'h3010, 8'h10, 3);
    reg_read(1'b0, 16'h0000, 8'h13, 1);
    // foreign address gets no acknowledge
    master.start();
    master.send_byte({7'h1b, 1'b0}, ack);
    cmp_bit("foreign ack", 1'b0, ack);
    master.stop();
    // frame class waits for the frame point, hold blocks it
    reg_write(16'h3020, 8'h77, 1);
    eff_check(11'h020, 8'h00);
    frame_point(1'b1);
    eff_check(11'h020, 8'h77);
    reg_write(16'h3001, 8'h01, 1);
    cmp_bit("hold set", 1'b1, hold);
    reg_write(16'h3020, 8'h88, 1);
    frame_point(1'b0);
    eff_check(11'h020, 8'h77);
    reg_write(16'h3001, 8'h00, 1);
    frame_point(1'b1);
    eff_check(11'h020, 8'h88);
    // immediate class written in standby, then standby left
    reg_write(16'h3047, 8'h3c, 1);
    eff_check(11'h047, 8'h3c);
    reg_write(16'h3000, 8'hfe, 1);
    cmp_bit("standby off", 1'b0, standby);
    reg_read(1'b1, 16'h3000, 8'h00, 1);
    // second reset restores the control bits
    @(posedge clk_in);
    #1 rst_n_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    cmp_bit("standby rst2", 1'b1, standby);
    wait_ready();
    reg_read(1'b1, 16'h3000, 8'h01, 1);
    complete_run();
  end
endmodule
